// ==== bench/ebpwm_bridge_model.sv ====
// Model of the external bridge switch drivers on the four PWM pins.
// Assumes a pull-down on every pad, so an undriven pin keeps its switch off.
`default_nettype none
module ebpwm_bridge_model
   import ebpwm_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [3:0] pinOut,
   input  wire logic [3:0] pinOe,
   output var  logic [3:0] pad,
   output var  int         shootCnt
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pad falls to the pull-down level, never the last driven value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad[i] = pinOe[i] ? pinOut[i] : 1'b0;
      end
   end
   // Both switches of one leg on means shoot-through; only valid for active-high
   initial shootCnt = 0;
   always @(posedge clock) begin
      if ((pad[0] && pad[1]) || (pad[2] && pad[3])) begin
         shootCnt <= shootCnt + 1;
      end
   end
endmodule // ebpwm_bridge_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the enhanced bridge PWM: register bus and pin timing.
// Assumes the design package and the bridge driver model in bench/.
`default_nettype none
module tb_top
   import ebpwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PER  = 8'h09;
   localparam int         PCLK = 40;
   logic         clock;
   logic         nrst;
   logic         sleepReq;
   ebpwmAxiReq_t req;
   ebpwmAxiRsp_t rsp;
   logic [3:0]   pinOut;
   logic [3:0]   pinOe;
   logic [3:0]   pad;
   logic [3:0]   padHeld;
   int           shootCnt;
   int           n_errors;
   int           checked;
   int           cycles;
   int           per;
   int           hi;
   int           cnt;
   int           mult;
   logic [31:0]  seed;
   logic [31:0]  rd;
   logic [31:0]  c0;
   logic [1:0]   resp;
   logic [9:0]   duty;
   logic [1:0]   ps;
   logic [1:0]   pol;
   logic         lvl;
   logic [3:0]   oeMask [4] = '{4'h1, 4'hF, 4'h3, 4'hF};

   ebpwm_top i_ebpwm_top (.clock(clock), .nrst(nrst), .axiReq(req), .axiRsp(rsp),
      .sleepReq(sleepReq), .pinOut(pinOut), .pinOe(pinOe));
   ebpwm_bridge_model i_ebpwm_bridge_model (.clock(clock), .pinOut(pinOut),
      .pinOe(pinOe), .pad(pad), .shootCnt(shootCnt));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under ten thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         end_sim();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Each channel held until its own ready is sampled high
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      @(posedge clock);
      req.awvalid <= 1'b1;
      req.awaddr  <= {26'h0000000, a};
      req.wvalid  <= 1'b1;
      req.wdata   <= {24'h000000, d};
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      aw = 1'b1;
      w  = 1'b1;
      while (aw || w) begin
         @(posedge clock);
         if (aw && rsp.awready === 1'b1) begin
            aw = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready === 1'b1) begin
            w = 1'b0;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   task automatic rdr(input logic [5:0] a);
      @(posedge clock);
      req.arvalid <= 1'b1;
      req.araddr  <= {26'h0000000, a};
      req.rready  <= 1'b1;
      do @(posedge clock); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clock); while (rsp.rvalid !== 1'b1);
      rd   = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask

   // Active time and rise-to-rise time of one pad; first rise may be a partial pulse
   task automatic meas(input int b);
      while (pad[b] !== 1'b0) @(posedge clock);
      while (pad[b] !== 1'b1) @(posedge clock);
      hi = 0;
      do begin
         @(posedge clock);
         hi++;
      end while (pad[b] === 1'b1);
      per = hi;
      do begin
         @(posedge clock);
         per++;
      end while (pad[b] !== 1'b1);
   endtask

   task automatic stay(input int b, input logic l);
      cnt = 0;
      repeat (4) @(posedge clock);
      repeat (2 * PCLK) begin
         @(posedge clock);
         if (pad[b] !== l) cnt++;
      end
   endtask

   // Pins released first, enabled again only once a fresh cycle has begun
   task automatic setup(input logic [1:0] m, input logic [9:0] d, input logic [1:0] p,
                        input logic [1:0] s);
      wr(OFS_PINDIR, 8'h0F);
      wr(OFS_PERIOD, PER);
      wr(OFS_CTRL, {m, d[1:0], PWM_SEL, p});
      wr(OFS_DUTY, d[9:2]);
      wr(OFS_STATUS, 8'h01);
      wr(OFS_TCTRL, {5'h00, 1'b1, s});
      do rdr(OFS_STATUS); while (rd[0] !== 1'b1);
      wr(OFS_PINDIR, 8'h00);
   endtask

   initial begin
      seed     = 32'hB6483867;
      cycles   = 0;
      n_errors = 0;
      checked  = 0;
      nrst     = 1'b0;
      sleepReq = 1'b0;
      req      = '0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      chk("reset pinOe", 32'h0, pinOe);
      rdr(OFS_PERIOD);
      chk("reset period", {24'h0, RST_PERIOD}, rd);
      rdr(OFS_PINDIR);
      chk("reset pindir", {28'h0, RST_PINDIR}, rd);
      rdr(OFS_CTRL);
      chk("reset ctrl", {24'h0, RST_CTRL}, rd);
      rdr(6'h24);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         duty = (i == 0) ? 10'h001 : (i == 1) ? 10'h027 : 10'(1 + rnd() % 39);
         ps   = (i < 4) ? 2'h0 : 2'(i - 3);
         mult = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
         setup(MODE_SINGLE, duty, 2'h0, ps);
         meas(0);
         meas(0);
         chk("period", PCLK * mult, per);
         chk("pulse", duty * mult, hi);
      end
      $display("test period and duty done");
      setup(MODE_SINGLE, 10'h000, 2'h0, 2'h0);
      stay(0, 1'b0);
      chk("zero duty", 32'h0, cnt);
      setup(MODE_SINGLE, 10'h02C, 2'h0, 2'h0);
      stay(0, 1'b1);
      chk("overlong duty", 32'h0, cnt);
      $display("test duty limits done");
      wr(OFS_DEAD, 8'h02);
      setup(MODE_HALF, 10'h014, 2'h0, 2'h0);
      meas(0);
      meas(0);
      chk("half a active", 12, hi);
      meas(1);
      meas(1);
      chk("half b active", 12, hi);
      wr(OFS_DEAD, 8'h06);
      repeat (PCLK) @(posedge clock);
      stay(0, 1'b0);
      chk("dead over duty", 32'h0, cnt);
      $display("test half bridge done");
      setup(MODE_FWD, 10'h027, 2'h0, 2'h0);
      meas(3);
      meas(3);
      chk("fwd d active", 39, hi);
      wr(OFS_CTRL, 8'hFC);
      while (pad[2] !== 1'b1) @(posedge clock);
      chk("swap a off", 32'h0, pad[0]);
      cnt = 0;
      lvl = 1'b0;
      do begin
         @(posedge clock);
         cnt++;
         lvl = lvl | pad[3];
      end while (pad[1] !== 1'b1);
      chk("swap lead", 16, cnt);
      chk("blank d", 32'h0, lvl);
      chk("shoot through", 32'h0, shootCnt);
      $display("test direction change done");
      for (int i = 0; i < 8; i++) begin
         pol = (i < 4) ? 2'h0 : 2'h3;
         setup(2'(i % 4), 10'h014, pol, 2'h0);
         repeat (PCLK) @(posedge clock);
         chk("mode pins", oeMask[i % 4], pinOe);
         if (i % 4 == 1) begin
            chk("fwd statics", {pol[1], pol[0], ~pol[1]}, pad[2:0]);
         end
         if (i % 4 == 3) begin
            chk("rev statics", {pol[0], ~pol[1], pol[1]}, {pad[3], pad[2], pad[0]});
         end
      end
      wr(OFS_CTRL, 8'h00);
      repeat (4) @(posedge clock);
      chk("released pins", 32'h0, pinOe);
      wr(OFS_DUTY, 8'h09);
      wr(OFS_STATUS, 8'h01);
      wr(OFS_CTRL, 8'h3C);
      do begin
         lvl = pad[0];
         rdr(OFS_STATUS);
         if (rd[0] !== 1'b1) begin
            chk("early pulse", 32'h0, lvl);
         end
      end while (rd[0] !== 1'b1);
      $display("test modes and polarity done");
      wr(OFS_DEAD, 8'h02);
      setup(MODE_HALF, 10'h014, 2'h0, 2'h0);
      while (pad[0] !== 1'b1) @(posedge clock);
      sleepReq <= 1'b1;
      repeat (4) @(posedge clock);
      padHeld = pad;
      rdr(OFS_COUNT);
      c0 = rd;
      repeat (30) @(posedge clock);
      rdr(OFS_COUNT);
      chk("sleep count", c0, rd);
      chk("sleep pins", padHeld, pad);
      sleepReq <= 1'b0;
      rdr(OFS_COUNT);
      chk("resume count", 32'h1, (rd === c0) || (rd === ((c0 == 9) ? 0 : c0 + 1)));
      $display("test sleep done");
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      chk("mid reset pinOe", 32'h0, pinOe);
      nrst <= 1'b1;
      rdr(OFS_PERIOD);
      chk("mid reset period", {24'h0, RST_PERIOD}, rd);
      $display("test second reset done");
      end_sim();
   end
endmodule // tb_top
`default_nettype wire

// ==== design/ebpwm_pkg.sv ====
// Constants, modes and bus carriers of the enhanced bridge PWM.
// Assumes one 50 MHz system clock and an AXI4-Lite master.
`default_nettype none
package ebpwm_pkg;
   localparam int unsigned CLK_MHZ = 50;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_DUTY   = 6'h04;
   localparam logic [5:0] OFS_PERIOD = 6'h08;
   localparam logic [5:0] OFS_TCTRL  = 6'h0C;
   localparam logic [5:0] OFS_DEAD   = 6'h10;
   localparam logic [5:0] OFS_STATUS = 6'h14;
   localparam logic [5:0] OFS_SHADOW = 6'h18;
   localparam logic [5:0] OFS_COUNT  = 6'h1C;
   localparam logic [5:0] OFS_PINDIR = 6'h20;
   // Reset values
   localparam logic [7:0] RST_CTRL   = 8'h00;
   localparam logic [7:0] RST_DUTY   = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hFF;
   localparam logic [2:0] RST_TCTRL  = 3'h0;
   localparam logic [6:0] RST_DEAD   = 7'h00;
   localparam logic [3:0] RST_PINDIR = 4'hF;
   // Field positions
   localparam int unsigned CTRL_MODE_LSB = 6;
   localparam int unsigned CTRL_DLOW_LSB = 4;
   localparam int unsigned CTRL_PSEL_LSB = 2;
   localparam int unsigned TCTRL_RUN_BIT = 2;
   localparam int unsigned STAT_OVF_BIT  = 0;
   localparam logic [1:0]  PWM_SEL       = 2'h3;
   // Timing counts and bus response codes
   localparam logic [3:0] PRESC_1  = 4'h0;
   localparam logic [3:0] PRESC_4  = 4'h3;
   localparam logic [3:0] PRESC_16 = 4'hF;
   localparam logic [8:0] DIR_LEAD = 9'h004;
   localparam int unsigned CLK_PER_INSTR_LOG2 = 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_FWD    = 2'h1,
      MODE_HALF   = 2'h2,
      MODE_REV    = 2'h3
   } ebpwmMode_t;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } ebpwmAxiReq_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ebpwmAxiRsp_t;
endpackage
`default_nettype wire

// ==== design/ebpwm_top.sv ====
// Enhanced bridge PWM: timebase, duty compare, dead band, bridge steering.
// Assumes an AXI4-Lite master on the same clock and an external pad per pin.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module ebpwm_top
   import ebpwm_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire ebpwmAxiReq_t axiReq,
   output var  ebpwmAxiRsp_t axiRsp,
   input  wire logic         sleepReq,
   output var  logic [3:0]   pinOut,
   output var  logic [3:0]   pinOe
);
   // Software-visible state
   logic [7:0]   ctrl_q, ctrl_d;
   logic [7:0]   dutyHi_q, dutyHi_d;
   logic [7:0]   period_q, period_d;
   logic [2:0]   tctrl_q, tctrl_d;
   logic [6:0]   dead_q, dead_d;
   logic [3:0]   pinDir_q, pinDir_d;
   logic         ovf_q, ovf_d;
   logic         awHeld_q, awHeld_d;
   logic         wHeld_q, wHeld_d;
   logic [31:0]  awAddr_q, awAddr_d;
   logic [7:0]   wData_q, wData_d;
   logic         wLane_q, wLane_d;
   ebpwmAxiRsp_t rsp_q, rsp_d;
   // Engine state
   logic [7:0]   count_q, count_d;
   logic [1:0]   fine_q, fine_d;
   logic [3:0]   psc_q, psc_d;
   logic [9:0]   shadow_q, shadow_d;
   logic         raw_q, raw_d;
   logic         armed_q, armed_d;
   logic         dir_q, dir_d;
   logic         chg_q, chg_d;
   logic [1:0][8:0] db_q, db_d;
   logic [1:0]   dbOut_q, dbOut_d;
   logic [3:0]   pinOut_q, pinOut_d;
   logic [3:0]   pinOe_q, pinOe_d;

   logic         pwmOn, fullBr, dirReq, run, subTick, wrap, swapTrig;
   logic [3:0]   pscLimit, act, used, inact;
   logic [9:0]   tb, dutyCat;
   logic [8:0]   dbLimit;
   ebpwmMode_t   mode;

   assign mode    = ebpwmMode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign pwmOn   = ctrl_q[CTRL_PSEL_LSB +: 2] == PWM_SEL;
   assign fullBr  = mode[0];
   assign dirReq  = mode[1];
   assign dutyCat = {dutyHi_q, ctrl_q[CTRL_DLOW_LSB +: 2]};
   assign tb      = {count_q, fine_q};
   assign dbLimit = {dead_q, 2'b00};
   // Inactive level per pin: A/C follow bit 1, B/D bit 0
   assign inact   = {ctrl_q[0], ctrl_q[1], ctrl_q[0], ctrl_q[1]};
   assign run     = tctrl_q[TCTRL_RUN_BIT] & ~sleepReq;

   // Prescaler counts raw system clocks, so PWM rate scales with it
   always_comb begin
      case (tctrl_q[1:0])
         2'h0:    pscLimit = PRESC_1;
         2'h1:    pscLimit = PRESC_4;
         default: pscLimit = PRESC_16;
      endcase
   end

   assign subTick  = run && (psc_q == pscLimit);
   assign wrap     = subTick && (fine_q == 2'h3) && (count_q == period_q);
   // Fires as the count steps into the last four counts of the period
   assign swapTrig = subTick && (fine_q == 2'h3) && fullBr && armed_q && !chg_q
                     && (dirReq != dir_q)
                     && ({1'b0, count_q} + 9'h001 + DIR_LEAD == {1'b0, period_q} + 9'h001);

   // Timebase, duty and direction engine
   always_comb begin
      count_d  = count_q;
      fine_d   = fine_q;
      psc_d    = psc_q;
      shadow_d = shadow_q;
      raw_d    = raw_q;
      armed_d  = armed_q;
      dir_d    = dir_q;
      chg_d    = chg_q;
      if (run) begin
         psc_d = subTick ? 4'h0 : psc_q + 4'h1;
      end
      if (subTick) begin
         fine_d = fine_q + 2'h1;
         if (fine_q == 2'h3) begin
            count_d = count_q + 8'h01;
         end
      end
      if (wrap) begin
         count_d  = 8'h00;
         shadow_d = dutyCat;
         raw_d    = dutyCat != 10'h000;
         chg_d    = 1'b0;
         armed_d  = 1'b1;
         // Short periods have no room for the early swap
         if (!armed_q || period_q < DIR_LEAD[7:0]) begin
            dir_d = dirReq;
         end
      end else if (!sleepReq && {count_d, fine_d} == shadow_q) begin
         // Next timebase compared, so the pin is already off while the match stands
         // Duty past the period never matches, so the pin holds
         raw_d = 1'b0;
      end
      if (swapTrig) begin
         chg_d = 1'b1;
         dir_d = dirReq;
      end
      if (!pwmOn) begin
         armed_d = 1'b0;
         chg_d   = 1'b0;
      end
   end

   // Dead band per half-bridge output (A and B), delays only the rising edge
   for (genvar i = 0; i < 2; i++) begin : gDead
      logic src;
      assign src = (i == 0) ? raw_q : ~raw_q;
      always_comb begin
         db_d[i]    = db_q[i];
         dbOut_d[i] = dbOut_q[i];
         if (!sleepReq) begin
            if (!src) begin
               db_d[i]    = 9'h000;
               dbOut_d[i] = 1'b0;
            end else if (db_q[i] == dbLimit) begin
               dbOut_d[i] = 1'b1;
            end else begin
               db_d[i] = db_q[i] + 9'h001;
            end
         end
      end
   end

   // Pin steering per mode
   always_comb begin
      act  = 4'h0;
      used = 4'hF;
      case (mode)
         MODE_SINGLE: begin
            act  = {3'h0, raw_q};
            used = 4'h1;
         end
         MODE_HALF: begin
            act  = {2'h0, dbOut_q};
            used = 4'h3;
         end
         default: begin
            // No dead band here, one leg switches at a time
            if (!dir_q) begin
               act = {raw_q & ~chg_q, 3'h1};
            end else begin
               act = {1'b0, 1'b1, raw_q & ~chg_q, 1'b0};
            end
         end
      endcase
      if (!armed_q) begin
         act = 4'h0;
      end
      pinOut_d = pinOut_q;
      pinOe_d  = pinOe_q;
      if (!sleepReq) begin
         pinOut_d = pwmOn ? (act ^ inact) : 4'h0;
         pinOe_d  = pwmOn ? (used & ~pinDir_q) : 4'h0;
      end
   end

   // Read mux; anything outside the map answers SLVERR
   function automatic logic [32:0] regRead(input logic [31:0] a);
      logic [31:0] v;
      logic        err;
      v   = 32'h0000_0000;
      err = 1'b0;
      if (a[31:6] != 26'h0) begin
         err = 1'b1;
      end else begin
         case (a[5:0])
            OFS_CTRL:   v[7:0]  = ctrl_q;
            OFS_DUTY:   v[7:0]  = dutyHi_q;
            OFS_PERIOD: v[7:0]  = period_q;
            OFS_TCTRL:  v[2:0]  = tctrl_q;
            OFS_DEAD:   v[6:0]  = dead_q;
            OFS_STATUS: v[0]    = ovf_q;
            OFS_SHADOW: v[9:0]  = shadow_q;
            OFS_COUNT:  v[7:0]  = count_q;
            OFS_PINDIR: v[3:0]  = pinDir_q;
            default:    err     = 1'b1;
         endcase
      end
      return {err, v};
   endfunction

   // AXI4-Lite slave and register writes
   always_comb begin
      logic [32:0] rd;
      logic        doWr;
      logic        ovfClr;
      rd       = regRead(axiReq.araddr);
      doWr     = awHeld_q && wHeld_q && !rsp_q.bvalid;
      ovfClr   = 1'b0;
      ctrl_d   = ctrl_q;
      dutyHi_d = dutyHi_q;
      period_d = period_q;
      tctrl_d  = tctrl_q;
      dead_d   = dead_q;
      pinDir_d = pinDir_q;
      awHeld_d = awHeld_q;
      wHeld_d  = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d  = wData_q;
      wLane_d  = wLane_q;
      rsp_d    = rsp_q;
      if (axiReq.awvalid && rsp_q.awready) begin
         awHeld_d = 1'b1;
         awAddr_d = axiReq.awaddr;
      end
      if (axiReq.wvalid && rsp_q.wready) begin
         wHeld_d = 1'b1;
         wData_d = axiReq.wdata[7:0];
         wLane_d = axiReq.wstrb[0];
      end
      if (rsp_q.bvalid && axiReq.bready) begin
         rsp_d.bvalid = 1'b0;
      end
      if (doWr) begin
         awHeld_d     = 1'b0;
         wHeld_d      = 1'b0;
         rsp_d.bvalid = 1'b1;
         rsp_d.bresp  = RESP_OKAY;
         if (awAddr_q[31:6] != 26'h0) begin
            rsp_d.bresp = RESP_SLVERR;
         end else if (wLane_q) begin
            case (awAddr_q[5:0])
               OFS_CTRL:   ctrl_d   = wData_q;
               OFS_DUTY:   dutyHi_d = wData_q;
               OFS_PERIOD: period_d = wData_q;
               OFS_TCTRL:  tctrl_d  = wData_q[2:0];
               OFS_DEAD:   dead_d   = wData_q[6:0];
               OFS_STATUS: ovfClr   = wData_q[STAT_OVF_BIT];
               OFS_PINDIR: pinDir_d = wData_q[3:0];
               OFS_SHADOW, OFS_COUNT: ;
               default:    rsp_d.bresp = RESP_SLVERR;
            endcase
         end
      end
      // A new period's flag beats a clear in the same cycle
      ovf_d = wrap | (ovf_q & ~ovfClr);
      rsp_d.awready = !awHeld_d;
      rsp_d.wready  = !wHeld_d;
      if (rsp_q.rvalid && axiReq.rready) begin
         rsp_d.rvalid = 1'b0;
      end
      if (axiReq.arvalid && rsp_q.arready) begin
         rsp_d.rvalid = 1'b1;
         rsp_d.rdata  = rd[31:0];
         rsp_d.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
      end
      rsp_d.arready = !rsp_d.rvalid;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_q   <= RST_CTRL;
         dutyHi_q <= RST_DUTY;
         period_q <= RST_PERIOD;
         tctrl_q  <= RST_TCTRL;
         dead_q   <= RST_DEAD;
         pinDir_q <= RST_PINDIR;
         ovf_q    <= 1'b0;
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 32'h0000_0000;
         wData_q  <= 8'h00;
         wLane_q  <= 1'b0;
         rsp_q    <= '0;
         count_q  <= 8'h00;
         fine_q   <= 2'h0;
         psc_q    <= 4'h0;
         shadow_q <= 10'h000;
         raw_q    <= 1'b0;
         armed_q  <= 1'b0;
         dir_q    <= 1'b0;
         chg_q    <= 1'b0;
         db_q     <= '0;
         dbOut_q  <= 2'h0;
         pinOut_q <= 4'h0;
         pinOe_q  <= 4'h0;
      end else begin
         ctrl_q   <= ctrl_d;
         dutyHi_q <= dutyHi_d;
         period_q <= period_d;
         tctrl_q  <= tctrl_d;
         dead_q   <= dead_d;
         pinDir_q <= pinDir_d;
         ovf_q    <= ovf_d;
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q  <= wData_d;
         wLane_q  <= wLane_d;
         rsp_q    <= rsp_d;
         count_q  <= count_d;
         fine_q   <= fine_d;
         psc_q    <= psc_d;
         shadow_q <= shadow_d;
         raw_q    <= raw_d;
         armed_q  <= armed_d;
         dir_q    <= dir_d;
         chg_q    <= chg_d;
         db_q     <= db_d;
         dbOut_q  <= dbOut_d;
         pinOut_q <= pinOut_d;
         pinOe_q  <= pinOe_d;
      end
   end

   assign axiRsp = rsp_q;
   assign pinOut = pinOut_q;
   assign pinOe  = pinOe_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   chk_wrap_restart: assert property (
      wrap |=> count_q == 8'h00 && fine_q == 2'h0 && raw_q == (shadow_q != 10'h000))
      else $error("period end did not restart timebase");
   chk_shadow_latch: assert property (
      wrap |=> shadow_q == $past(dutyCat))
      else $error("duty shadow not latched at period end");
   chk_duty_match: assert property (
      raw_q |-> tb != shadow_q)
      else $error("timebase match did not end pulse");
   chk_sleep_hold: assert property (
      sleepReq |=> $stable(count_q) && $stable(pinOut_q) && $stable(pinOe_q))
      else $error("state moved during sleep");
   chk_reset_inputs: assert property (
      $rose(nrst) |-> pinOe_q == 4'h0 && pinDir_q == RST_PINDIR)
      else $error("pins not inputs after reset");
   chk_single_free: assert property (
      !sleepReq && mode == MODE_SINGLE |=> pinOe_q[3:1] == 3'h0)
      else $error("unused pins driven in single mode");
   chk_release_all: assert property (
      !sleepReq && ctrl_q == 8'h00 |=> pinOe_q == 4'h0 ##1 pinOe_q == 4'h0 || ctrl_q != 8'h00)
      else $error("cleared control did not release pins");
   chk_first_quiet: assert property (
      pwmOn && !armed_q && !sleepReq |=> pinOut_q == $past(inact))
      else $error("output before first full period");
   chk_half_overlap: assert property (
      mode == MODE_HALF |-> !(dbOut_q[0] && dbOut_q[1]))
      else $error("both half-bridge legs active");
   chk_swap_blank: assert property (
      swapTrig |=> chg_q && dir_q != $past(dir_q))
      else $error("direction swap not blanked");
   chk_resume_next: assert property (
      wrap |=> !chg_q)
      else $error("blanking ran past period end");
endmodule // ebpwm_top
`default_nettype wire
